// ===== hdl/sbrg_prescale.sv
// Programmable prescaler: one enable pulse every n input enables
`timescale 1ns/100ps
`include "sbrg_cfg.svh"
module sbrg_prescale
	import sbrg_pkg::*;
(
	// Clock and reset
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rst_n,
	// Control
	input  wire logic                        i_restart,
	input  wire logic                        i_en,
	input  wire logic [`SBRG_PRE_CNT_W-1:0]  i_div,
	// Output enable
	output logic                             o_tick
);
	typedef struct packed {
		logic [`SBRG_PRE_CNT_W-1:0] cnt;
		logic                       tick;
	} sbrg_pre_st_t;

	sbrg_pre_st_t st_reg;
	sbrg_pre_st_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (i_restart) begin
			st_next.cnt = '0;
		end else if (i_en) begin
			if (st_reg.cnt >= i_div - 4'h1) begin
				st_next.cnt = '0;
				st_next.tick = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_tick = st_reg.tick;
endmodule : sbrg_prescale

// ===== hdl/sbrg_top.sv
// Baud rate generator: register, prescaler and power-of-two divider chain
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "sbrg_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Rate code n divides by two to n
// - Rate field read/write, reset to zero
// - Baud equals clock over 64, prescale, rate
// - Chain runs from bus clock only
// - Prescaler codes give 1, 3, 4, 13
// - Reset clears prescaler field, divide one
// - One rate serves transmitter and receiver
module sbrg_top
	import sbrg_pkg::*;
(
	// Clock and reset
	input  wire logic                     i_core_clk,
	input  wire logic                     i_rst_n,
	// Register port
	input  wire logic [`SBRG_ADDR_W-1:0]  i_addr,
	input  wire logic [7:0]               i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [7:0]               o_rdata,
	// Ticks to transmitter and receiver
	output logic                          o_tx_tick,
	output logic                          o_rx_tick,
	output logic                          o_baud_tick
);
	typedef struct packed {
		sbrg_pre_sel_t                pre_sel;
		sbrg_rate_sel_t               rate_sel;
		logic [`SBRG_RATE_CNT_W-1:0]  rate_cnt;
		logic [`SBRG_FIXED_CNT_W-1:0] fix_cnt;
		logic                         os_tick;
		logic                         baud_tick;
		logic [7:0]                   rdata;
		logic                         restart;
		sbrg_state_t                  state;
		logic [10:0]                  gap_cnt;
		logic                         gap_armed;
	} sbrg_st_t;

	sbrg_st_t st_reg;
	sbrg_st_t st_next;

	logic [`SBRG_PRE_CNT_W-1:0]  pre_div;
	logic [`SBRG_RATE_CNT_W:0]   rate_div;
	logic [`SBRG_RATE_CNT_W-1:0] rate_last;
	logic [10:0]                 chk_pre;
	logic [10:0]                 chk_rate;
	logic [10:0]                 chk_period;
	logic                        pre_tick;
	logic [7:0]                  baud_sel_rd;

	////////////////////////////////////////////////////////////////////////////
	// Divisor decode
	always_comb begin
		case (st_reg.pre_sel)
			2'b00: pre_div = `SBRG_PRE_DIV_CODE0;
			2'b01: pre_div = `SBRG_PRE_DIV_CODE1;
			2'b10: pre_div = `SBRG_PRE_DIV_CODE2;
			2'b11: pre_div = `SBRG_PRE_DIV_CODE3;
			default: pre_div = `SBRG_PRE_DIV_CODE0;
		endcase
	end

	// One bit wider than the counter, since code 7 divides by 128
	assign rate_div = 8'h01 << st_reg.rate_sel;
	assign rate_last = 7'(rate_div - 8'h01);

	assign baud_sel_rd = {2'b00, st_reg.pre_sel, 1'b0, st_reg.rate_sel};

	////////////////////////////////////////////////////////////////////////////
	// Stage one: prescaler, enabled every bus clock
	sbrg_prescale u_pre (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_restart  (st_reg.restart),
		.i_en       (1'b1),
		.i_div      (pre_div),
		.o_tick     (pre_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register port and remaining chain
	always_comb begin
		st_next = st_reg;
		st_next.os_tick = 1'b0;
		st_next.baud_tick = 1'b0;
		st_next.restart = 1'b0;
		st_next.rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				`SBRG_OFS_BAUD_SEL: st_next.rdata = baud_sel_rd;
				`SBRG_OFS_STATUS: st_next.rdata = 8'(st_reg.fix_cnt);
				default: st_next.rdata = 8'h00;
			endcase
		end
		case (st_reg.state)
			SBRG_ST_RUN: begin
				if (pre_tick) begin
					// Rate divider sits before the fixed /64, so ticks run at 64x baud
					if (st_reg.rate_cnt >= rate_last) begin
						st_next.rate_cnt = '0;
						st_next.os_tick = 1'b1;
						// Fixed stage counts ticks; its wrap marks one baud period
						st_next.fix_cnt = st_reg.fix_cnt + 6'h01;
						if (st_reg.fix_cnt == 6'h3F) begin
							st_next.baud_tick = 1'b1;
						end
					end else begin
						st_next.rate_cnt = st_reg.rate_cnt + 7'h01;
					end
				end
			end
			SBRG_ST_RELOAD: begin
				// Fresh start avoids one odd-length period after a rate change
				st_next.rate_cnt = '0;
				st_next.fix_cnt = '0;
				st_next.state = SBRG_ST_RUN;
			end
			default: st_next.state = SBRG_ST_RUN;
		endcase
		// Spacing monitor for the checks; ticks of a stale setting never arm it
		if (st_reg.os_tick) begin
			st_next.gap_cnt = 11'h001;
			st_next.gap_armed = (st_reg.state == SBRG_ST_RUN);
		end else if (st_reg.gap_cnt != 11'h7FF) begin
			st_next.gap_cnt = st_reg.gap_cnt + 11'h001;
		end
		if (i_wr && i_addr == `SBRG_OFS_BAUD_SEL) begin
			st_next.gap_armed = 1'b0;
			st_next.rate_sel = i_wdata[`SBRG_RATE_SEL_MSB:`SBRG_RATE_SEL_LSB];
			st_next.pre_sel = {i_wdata[`SBRG_PRE_SEL_HIGH], i_wdata[`SBRG_PRE_SEL_LOW]};
			st_next.restart = 1'b1;
			st_next.state = SBRG_ST_RELOAD;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_rdata = st_reg.rdata;
	assign o_tx_tick = st_reg.os_tick;
	assign o_rx_tick = st_reg.os_tick;
	assign o_baud_tick = st_reg.baud_tick;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_tick_single: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_reg.os_tick && (st_reg.pre_sel != 2'b00 || st_reg.rate_sel != 3'h0))
		|=> !st_reg.os_tick)
		else $error("oversample tick longer than one cycle");

	a_div1_rate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_reg.os_tick && st_reg.pre_sel == 2'b00 && st_reg.rate_sel == 3'h0 && !i_wr
		&& st_reg.state == SBRG_ST_RUN)
		|=> st_reg.os_tick)
		else $error("divide-by-one tick missed");

	a_pre_three: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_reg.os_tick && st_reg.pre_sel == 2'b01 && st_reg.rate_sel == 3'h0)
		|=> !st_reg.os_tick ##1 !st_reg.os_tick)
		else $error("prescale by three too fast");

	a_rate_two: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_reg.os_tick && st_reg.pre_sel == 2'b00 && st_reg.rate_sel == 3'h1 && !i_wr
		&& st_reg.state == SBRG_ST_RUN)
		|=> !st_reg.os_tick ##1 st_reg.os_tick)
		else $error("rate divide by two wrong");

	a_reg_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == `SBRG_OFS_BAUD_SEL) |=> st_reg.rate_sel == $past(i_wdata[2:0]))
		else $error("rate field not written");

	a_pre_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == `SBRG_OFS_BAUD_SEL) |=> st_reg.pre_sel == $past(i_wdata[5:4]))
		else $error("prescaler field not written");

	a_read_back: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_rd && !i_wr && i_addr == `SBRG_OFS_BAUD_SEL) |=> o_rdata == $past(baud_sel_rd))
		else $error("baud select read back wrong");

	a_same_ticks: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_tx_tick == o_rx_tick)
		else $error("transmit and receive ticks differ");

	a_baud_once: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		st_reg.baud_tick |-> $past(st_reg.fix_cnt) == 6'h3F)
		else $error("baud tick not at end of fixed stage");

	////////////////////////////////////////////////////////////////////////////
	// Expected tick spacing, decoded apart from the chain
	always_comb begin
		case (st_reg.pre_sel)
			2'b00: chk_pre = {7'h00, `SBRG_PRE_DIV_CODE0};
			2'b01: chk_pre = {7'h00, `SBRG_PRE_DIV_CODE1};
			2'b10: chk_pre = {7'h00, `SBRG_PRE_DIV_CODE2};
			2'b11: chk_pre = {7'h00, `SBRG_PRE_DIV_CODE3};
			default: chk_pre = {7'h00, `SBRG_PRE_DIV_CODE0};
		endcase
	end

	assign chk_rate = 11'h001 << st_reg.rate_sel;
	assign chk_period = 11'(chk_pre * chk_rate);

	a_tick_spacing: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_reg.os_tick && st_reg.gap_armed) |-> st_reg.gap_cnt == chk_period)
		else $error("tick spacing differs from prescale times rate");

	a_reset_clear: assert property (@(posedge i_core_clk)
		!i_rst_n |=> baud_sel_rd == `SBRG_BAUD_SEL_RST)
		else $error("select fields not cleared by reset");

	a_rdata_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data outside a read cycle");

	a_baud_on_tick: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		st_reg.baud_tick |-> st_reg.os_tick)
		else $error("baud tick without oversample tick");

	a_write_restart: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == `SBRG_OFS_BAUD_SEL)
		|=> (st_reg.state == SBRG_ST_RELOAD && st_reg.restart))
		else $error("write did not restart the chain");

	a_reload_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		st_reg.state == SBRG_ST_RELOAD |=> (!st_reg.os_tick && st_reg.rate_cnt == 7'h00))
		else $error("tick during chain reload");
endmodule : sbrg_top

// ===== inc/sbrg_cfg.svh
// Register offsets, field positions, reset values and divider counts
`ifndef SBRG_CFG_SVH
`define SBRG_CFG_SVH

`define SBRG_ADDR_W          4
`define SBRG_OFS_BAUD_SEL    4'h0
`define SBRG_OFS_STATUS      4'h1
`define SBRG_RATE_SEL_LSB    0
`define SBRG_RATE_SEL_MSB    2
`define SBRG_PRE_SEL_LOW     4
`define SBRG_PRE_SEL_HIGH    5
`define SBRG_BAUD_SEL_RST    8'h00
`define SBRG_BAUD_SEL_MASK   8'h37
`define SBRG_PRE_DIV_CODE0   4'h1
`define SBRG_PRE_DIV_CODE1   4'h3
`define SBRG_PRE_DIV_CODE2   4'h4
`define SBRG_PRE_DIV_CODE3   4'hD
`define SBRG_PRE_CNT_W       4
`define SBRG_RATE_CNT_W      7
`define SBRG_FIXED_DIV       7'h40
`define SBRG_FIXED_CNT_W     6

`endif

// ===== inc/sbrg_pkg.sv
// Types shared by the baud rate generator
package sbrg_pkg;
	typedef logic [1:0] sbrg_pre_sel_t;
	typedef logic [2:0] sbrg_rate_sel_t;
	typedef enum logic [0:0] {
		SBRG_ST_RUN   = 1'b0,
		SBRG_ST_RELOAD = 1'b1
	} sbrg_state_t;
endpackage : sbrg_pkg

// ===== tb/sbrg_tick_sink.sv
// Tick consumer model: measures tick spacing
`timescale 1ns/100ps
module sbrg_tick_sink (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// Ticks
	input  wire logic        i_tx_tick,
	input  wire logic        i_rx_tick,
	input  wire logic        i_baud_tick,
	// Measurements
	output logic      [31:0] o_gap,
	output logic      [31:0] o_baud_gap,
	output logic             o_split
);
	logic [31:0] cnt_reg;
	logic [31:0] bcnt_reg;
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			cnt_reg    <= 32'h0000_0000;
			bcnt_reg   <= 32'h0000_0000;
			o_gap      <= 32'h0000_0000;
			o_baud_gap <= 32'h0000_0000;
			o_split    <= 1'b0;
		end else begin
			cnt_reg  <= i_tx_tick ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
			bcnt_reg <= i_baud_tick ? 32'h0000_0000 : bcnt_reg + 32'h0000_0001;
			if (i_tx_tick)
				o_gap <= cnt_reg + 32'h0000_0001;
			if (i_baud_tick)
				o_baud_gap <= bcnt_reg + 32'h0000_0001;
			// Sticky, so a single split cycle is not lost
			if (i_tx_tick !== i_rx_tick)
				o_split <= 1'b1;
		end
	end
endmodule : sbrg_tick_sink

// ===== tb/test_sbrg_top.sv
// Register and tick-rate tests for the baud rate generator
`timescale 1ns/100ps
module test_sbrg_top;
	logic        i_core_clk;
	logic        i_rst_n;
	logic [3:0]  i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [7:0]  o_rdata;
	logic        tx_tick;
	logic        rx_tick;
	logic        baud_tick;
	logic [31:0] gap;
	logic [31:0] baud_gap;
	logic        split;
	int          miscompares = 0;
	int          compares = 0;
	int          cyc = 0;
	int          pre_tab[4] = '{1, 3, 4, 13};
	int          n;
	sbrg_top dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_tx_tick(tx_tick), .o_rx_tick(rx_tick), .o_baud_tick(baud_tick));
	sbrg_tick_sink sink (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_tx_tick(tx_tick), .i_rx_tick(rx_tick), .i_baud_tick(baud_tick),
		.o_gap(gap), .o_baud_gap(baud_gap), .o_split(split));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_of_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		@(posedge i_core_clk);
		// Taken at the edge that ends the data cycle, before it clears
		chk("rdata", {24'h00_0000, o_rdata}, {24'h00_0000, exp});
	endtask : rd
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		i_rst_n = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rd(4'h0, 8'h00);
		wr(4'h0, 8'hFF);
		rd(4'h0, 8'h37);
		rd(4'hF, 8'h00);
		for (int p = 0; p < 4; p++) begin
			for (int r = 0; r < 8; r++) begin
				n = pre_tab[p] * (1 << r);
				wr(4'h0, {2'b00, p[1:0], 1'b0, r[2:0]});
				rd(4'h0, {2'b00, p[1:0], 1'b0, r[2:0]});
				// Fixed stage is still cleared from the restart
				rd(4'h1, 8'h00);
				// Slow settings skip the baud check to bound run time
				repeat (n <= 4 ? 192 * n + 8 : 3 * n + 8) @(posedge i_core_clk);
				chk("tick gap", gap, n);
				if (n <= 4)
					chk("baud gap", baud_gap, 64 * n);
			end
		end
		chk("tx rx split", {31'h0000_0000, split}, 32'h0000_0000);
		// Reset in mid-run, with both fields set, must clear them again
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rd(4'h0, 8'h00);
		end_of_test();
	end
endmodule : test_sbrg_top
